/* File: common/pfmux_params.svh */
// Constants for the programmable function pin multiplexer.
// Assumes that it is included by bare name from files that need these values.
`ifndef PFMUX_PARAMS_SVH
`define PFMUX_PARAMS_SVH

// ==========================================================
// Pin counts and numbering.
`define PFMUX_NUM_PINS 29
`define PFMUX_FIRST_PF 3
`define PFMUX_NUM_FUNCS 22

// ==========================================================
// Strap codes, CFG_STRAP[1:0] order.
`define PFMUX_STRAP_CFG1 2'h0
`define PFMUX_STRAP_CFG2 2'h1

`endif

/* File: common/pfmux_pkg.sv */
// Types of the programmable function pin multiplexer.
// Assumes nothing of its surroundings.
package pfmux_pkg;

  // ==========================================================
  // Selectable pin functions.
  typedef enum logic [4:0] {
    PFMUX_FN_NONE = 5'h00,
    PFMUX_FN_CORE = 5'h01,
    PFMUX_FN_BRIDGE_MASTER_SERIAL_CLOCK = 5'h02,
    PFMUX_FN_BRIDGE_MASTER_SERIAL_DATA = 5'h03,
    PFMUX_FN_TARGET_PORT_SERIAL_CLOCK = 5'h04,
    PFMUX_FN_TARGET_PORT_SERIAL_DATA = 5'h05,
    PFMUX_FN_MEM_SELECT_N = 5'h06,
    PFMUX_FN_MEM_CLOCK = 5'h07,
    PFMUX_FN_MEM_LANE0 = 5'h08,
    PFMUX_FN_MEM_LANE1 = 5'h09,
    PFMUX_FN_MEM_LANE2 = 5'h0A,
    PFMUX_FN_MEM_LANE3 = 5'h0B,
    PFMUX_FN_AUDIO_DATA_IN = 5'h0C,
    PFMUX_FN_AUDIO_DATA_OUT = 5'h0D,
    PFMUX_FN_AUDIO_BIT_CLOCK = 5'h0E,
    PFMUX_FN_AUDIO_WORD_SELECT = 5'h0F,
    PFMUX_FN_AUDIO_MASTER_CLOCK = 5'h10,
    PFMUX_FN_MICROPHONE_PRESENT = 5'h11,
    PFMUX_FN_PD_COMPANION_IRQ_IN = 5'h12,
    PFMUX_FN_PORT1_CABLE_POWER_A_EN = 5'h13,
    PFMUX_FN_PORT1_CABLE_POWER_B_EN = 5'h14,
    PFMUX_FN_PORT1_BLEED_EN = 5'h15
  } pfmux_func_t;

  // ==========================================================
  // Origin of an override write.
  typedef enum logic [1:0] {
    PFMUX_SRC_CFG_STAGE = 2'h0,
    PFMUX_SRC_OTP = 2'h1,
    PFMUX_SRC_SMBUS_RUNTIME = 2'h2,
    PFMUX_SRC_USB_RUNTIME = 2'h3
  } pfmux_src_t;

endpackage

/* File: hdl/pfmux_pin_cell.sv */
// Output stage of one programmable function pin.
// Assumes a registered function select and core-side drive requests.
`timescale 1ns/10ps
`default_nettype none
module pfmux_pin_cell
(
  input wire pfmux_pkg::pfmux_func_t i_sel,
  input wire logic [21:0] i_func_out,
  input wire logic [21:0] i_func_oe,
  input wire logic i_core_out,
  input wire logic i_core_oe,
  input wire logic i_spi_en,
  input wire logic i_powerdown,
  output logic o_pin_out,
  output logic o_pin_oe_n
);
  import pfmux_pkg::*;

  // ==========================================================
  // Function to pin steering.
  logic drive;
  always_comb
  begin
    drive = 1'h0;
    o_pin_out = 1'h0;
    case (i_sel)
      PFMUX_FN_NONE,
      PFMUX_FN_AUDIO_DATA_IN,
      PFMUX_FN_MICROPHONE_PRESENT,
      PFMUX_FN_PD_COMPANION_IRQ_IN:
      begin
        drive = 1'h0;
      end
      PFMUX_FN_CORE:
      begin
        drive = i_core_oe;
        o_pin_out = i_core_out;
      end
      PFMUX_FN_AUDIO_DATA_OUT,
      PFMUX_FN_AUDIO_BIT_CLOCK,
      PFMUX_FN_AUDIO_WORD_SELECT,
      PFMUX_FN_AUDIO_MASTER_CLOCK,
      PFMUX_FN_PORT1_CABLE_POWER_A_EN,
      PFMUX_FN_PORT1_CABLE_POWER_B_EN,
      PFMUX_FN_PORT1_BLEED_EN:
      begin
        drive = 1'h1; // see R8 see R9
        o_pin_out = i_func_out[i_sel];
      end
      PFMUX_FN_MEM_SELECT_N:
      begin
        drive = i_spi_en & (i_powerdown | i_func_oe[i_sel]);
        o_pin_out = i_powerdown | i_func_out[i_sel]; // see R4
      end
      PFMUX_FN_MEM_CLOCK,
      PFMUX_FN_MEM_LANE0,
      PFMUX_FN_MEM_LANE1,
      PFMUX_FN_MEM_LANE2,
      PFMUX_FN_MEM_LANE3:
      begin
        drive = i_spi_en & i_func_oe[i_sel]; // see R5
        o_pin_out = i_func_out[i_sel];
      end
      default:
      begin
        drive = i_func_oe[i_sel];
        o_pin_out = i_func_out[i_sel];
      end
    endcase
    o_pin_oe_n = ~drive;
  end
endmodule
`default_nettype wire

/* File: hdl/pfmux_top.sv */
// Programmable function pin multiplexer with strap defaults and override writes.
// Assumes pins and core signals synchronous to I_REF_CLK.
//
// Function
// R1: Each pin's default function can be replaced through a writable per-pin select.
// R2: Overrides are taken in the configuration stage, from OTP, or at runtime over SMBus or USB after enumeration.
// R3: The outside party keeps the memory clock low while the hub is in reset.
// R4: The memory select is active low and is driven high in powerdown while the memory port is enabled.
// R5: The four memory data pins act as lanes 3 to 0 of a quad memory interface.
// R6: The microphone input reads 0 for no microphone and 1 for a microphone present.
// R7: The companion interrupt input is watched and its assertion raises an event.
// R8: Audio word select, bit clock, master clock and data out are driven; audio data in is sampled.
// R9: Two cable power enables and a bleed enable for port 1 are driven outputs.
// R10: Two straps choose between the serial-bus default set and the audio default set.
// R11: A write changes only its own pin and takes effect on the next clock.
`timescale 1ns/10ps
`default_nettype none
`include "pfmux_params.svh"
module pfmux_top
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic [1:0] I_CFG_STRAP,
  input wire logic I_CFG_STAGE,
  input wire logic I_ENUMERATED,
  input wire logic I_SPI_EN,
  input wire logic I_POWERDOWN,
  input wire logic I_WR_EN,
  input wire logic [4:0] I_WR_PIN,
  input wire pfmux_pkg::pfmux_func_t I_WR_FUNC,
  input wire pfmux_pkg::pfmux_src_t I_WR_SRC,
  output logic O_WR_ACCEPT,
  input wire logic [21:0] I_FUNC_OUT,
  input wire logic [21:0] I_FUNC_OE,
  output logic [21:0] O_FUNC_IN,
  input wire logic [28:0] I_CORE_OUT,
  input wire logic [28:0] I_CORE_OE,
  input wire logic [28:0] I_PF_IN,
  output logic [28:0] O_PF_OUT,
  output logic [28:0] O_PF_OE_N,
  output logic O_MICROPHONE_PRESENT,
  output logic O_PD_IRQ_N,
  output logic O_PD_IRQ_EVENT,
  output logic O_DEFAULTS_LOADED
);
  import pfmux_pkg::*;

  localparam int NPINS = `PFMUX_NUM_PINS;

  // ==========================================================
  // Default function of a pin for the strapped configuration.
  function automatic pfmux_func_t pfmux_default(input logic [4:0] idx, input logic cfg2);
    pfmux_func_t f;
    f = PFMUX_FN_CORE;
    case (5'(idx + 5'(`PFMUX_FIRST_PF)))
      5'h03: f = PFMUX_FN_PORT1_CABLE_POWER_B_EN;
      5'h04: f = PFMUX_FN_PORT1_CABLE_POWER_A_EN;
      5'h05: f = PFMUX_FN_PORT1_BLEED_EN;
      5'h07: f = cfg2 ? PFMUX_FN_MICROPHONE_PRESENT : PFMUX_FN_CORE;
      5'h0A: f = cfg2 ? PFMUX_FN_AUDIO_DATA_IN : PFMUX_FN_CORE;
      5'h0B: f = cfg2 ? PFMUX_FN_AUDIO_MASTER_CLOCK : PFMUX_FN_CORE;
      5'h12: f = PFMUX_FN_PD_COMPANION_IRQ_IN;
      5'h13: f = cfg2 ? PFMUX_FN_AUDIO_DATA_OUT : PFMUX_FN_NONE;
      5'h14: f = PFMUX_FN_MEM_SELECT_N;
      5'h15: f = PFMUX_FN_MEM_CLOCK;
      5'h16: f = PFMUX_FN_MEM_LANE0;
      5'h17: f = PFMUX_FN_MEM_LANE1;
      5'h18: f = PFMUX_FN_MEM_LANE2;
      5'h19: f = PFMUX_FN_MEM_LANE3;
      5'h1A: f = cfg2 ? PFMUX_FN_AUDIO_BIT_CLOCK : PFMUX_FN_TARGET_PORT_SERIAL_CLOCK;
      5'h1B: f = cfg2 ? PFMUX_FN_CORE : PFMUX_FN_TARGET_PORT_SERIAL_DATA;
      5'h1C: f = cfg2 ? PFMUX_FN_AUDIO_WORD_SELECT : PFMUX_FN_CORE;
      5'h1E: f = PFMUX_FN_BRIDGE_MASTER_SERIAL_CLOCK;
      5'h1F: f = PFMUX_FN_BRIDGE_MASTER_SERIAL_DATA;
      default: f = PFMUX_FN_CORE;
    endcase
    return f;
  endfunction

  // ==========================================================
  // Strap capture and override acceptance.
  logic cfg2;
  logic loaded;
  pfmux_func_t sel [NPINS];

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cfg2 <= 1'h0;
      loaded <= 1'h0;
    end
    else if (!loaded)
    begin
      cfg2 <= (I_CFG_STRAP == `PFMUX_STRAP_CFG2); // see R10
      loaded <= 1'h1;
    end
  end

  always_comb
  begin
    O_WR_ACCEPT = 1'h0;
    if (I_WR_EN && loaded && (I_WR_PIN < 5'(NPINS)))
    begin
      case (I_WR_SRC)
        PFMUX_SRC_CFG_STAGE: O_WR_ACCEPT = I_CFG_STAGE; // see R2
        PFMUX_SRC_OTP: O_WR_ACCEPT = !I_ENUMERATED;
        PFMUX_SRC_SMBUS_RUNTIME,
        PFMUX_SRC_USB_RUNTIME: O_WR_ACCEPT = I_ENUMERATED;
        default: O_WR_ACCEPT = 1'h0;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < NPINS; i++)
        sel[i] <= PFMUX_FN_NONE;
    end
    else if (!loaded)
    begin
      for (int i = 0; i < NPINS; i++)
        sel[i] <= pfmux_default(5'(i), I_CFG_STRAP == `PFMUX_STRAP_CFG2); // see R10
    end
    else if (O_WR_ACCEPT)
    begin
      sel[I_WR_PIN] <= I_WR_FUNC; // see R1 see R11
    end
  end

  assign O_DEFAULTS_LOADED = loaded;

  // ==========================================================
  // Pin output stages.
  for (genvar g = 0; g < NPINS; g++)
  begin : g_pin
    pfmux_pin_cell u_cell (
      .i_sel(sel[g]),
      .i_func_out(I_FUNC_OUT),
      .i_func_oe(I_FUNC_OE),
      .i_core_out(I_CORE_OUT[g]),
      .i_core_oe(I_CORE_OE[g]),
      .i_spi_en(I_SPI_EN),
      .i_powerdown(I_POWERDOWN),
      .o_pin_out(O_PF_OUT[g]),
      .o_pin_oe_n(O_PF_OE_N[g])
    );
  end

  // ==========================================================
  // Pin to function return path.
  logic [21:0] next_func_in;
  logic irq_seen;
  logic next_irq_n;
  always_comb
  begin
    next_func_in = '0;
    irq_seen = 1'h0;
    for (int i = 0; i < NPINS; i++)
    begin
      if (sel[i] != PFMUX_FN_NONE && sel[i] != PFMUX_FN_CORE)
        next_func_in[sel[i]] = next_func_in[sel[i]] | I_PF_IN[i]; // see R8
      if (sel[i] == PFMUX_FN_PD_COMPANION_IRQ_IN)
        irq_seen = 1'h1;
    end
    next_irq_n = irq_seen ? next_func_in[PFMUX_FN_PD_COMPANION_IRQ_IN] : 1'h1;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_FUNC_IN <= '0;
      O_MICROPHONE_PRESENT <= 1'h0;
    end
    else
    begin
      O_FUNC_IN <= next_func_in;
      O_MICROPHONE_PRESENT <= next_func_in[PFMUX_FN_MICROPHONE_PRESENT]; // see R6
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_PD_IRQ_N <= 1'h1;
      O_PD_IRQ_EVENT <= 1'h0;
    end
    else
    begin
      O_PD_IRQ_N <= next_irq_n;
      O_PD_IRQ_EVENT <= O_PD_IRQ_N & ~next_irq_n; // see R7
    end
  end

  // ==========================================================
  // Checks.
  logic bad_sel;
  logic bad_lane;
  logic bad_audio;
  logic bad_cable;
  logic [NPINS-1:0] mic_mask;
  always_comb
  begin
    bad_sel = 1'h0;
    bad_lane = 1'h0;
    bad_audio = 1'h0;
    bad_cable = 1'h0;
    mic_mask = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      mic_mask[i] = (sel[i] == PFMUX_FN_MICROPHONE_PRESENT);
      if (sel[i] == PFMUX_FN_MEM_SELECT_N && I_SPI_EN && I_POWERDOWN && (O_PF_OE_N[i] || !O_PF_OUT[i]))
        bad_sel = 1'h1;
      if (sel[i] == PFMUX_FN_MEM_LANE2 && I_SPI_EN && I_FUNC_OE[PFMUX_FN_MEM_LANE2]
          && (O_PF_OE_N[i] || O_PF_OUT[i] != I_FUNC_OUT[PFMUX_FN_MEM_LANE2]))
        bad_lane = 1'h1;
      if ((sel[i] == PFMUX_FN_AUDIO_WORD_SELECT || sel[i] == PFMUX_FN_AUDIO_BIT_CLOCK) && O_PF_OE_N[i])
        bad_audio = 1'h1;
      if (sel[i] == PFMUX_FN_AUDIO_DATA_IN && !O_PF_OE_N[i])
        bad_audio = 1'h1;
      if ((sel[i] == PFMUX_FN_PORT1_CABLE_POWER_A_EN || sel[i] == PFMUX_FN_PORT1_BLEED_EN)
          && (O_PF_OE_N[i] || O_PF_OUT[i] != I_FUNC_OUT[sel[i]]))
        bad_cable = 1'h1;
    end
  end

  property p_r1_write_lands;
    @(posedge I_REF_CLK) disable iff (I_RST)
    O_WR_ACCEPT |=> sel[$past(I_WR_PIN)] == $past(I_WR_FUNC);
  endproperty
  a_r1_write_lands: assert property (p_r1_write_lands) else $error("Accepted write did not land."); // see R1

  property p_r2_runtime_gate;
    @(posedge I_REF_CLK) disable iff (I_RST)
    (I_WR_EN && I_WR_SRC == PFMUX_SRC_USB_RUNTIME && !I_ENUMERATED) |-> !O_WR_ACCEPT;
  endproperty
  a_r2_runtime_gate: assert property (p_r2_runtime_gate) else $error("Runtime write taken early."); // see R2

  property p_r4_select_high;
    @(posedge I_REF_CLK) disable iff (I_RST)
    !bad_sel;
  endproperty
  a_r4_select_high: assert property (p_r4_select_high) else $error("Memory select not high in powerdown."); // see R4

  property p_r5_lane;
    @(posedge I_REF_CLK) disable iff (I_RST)
    !bad_lane;
  endproperty
  a_r5_lane: assert property (p_r5_lane) else $error("Memory lane not steered."); // see R5

  property p_r6_mic;
    @(posedge I_REF_CLK) disable iff (I_RST)
    loaded |=> O_MICROPHONE_PRESENT == $past(|(I_PF_IN & mic_mask));
  endproperty
  a_r6_mic: assert property (p_r6_mic) else $error("Microphone level wrong."); // see R6

  property p_r7_irq;
    @(posedge I_REF_CLK) disable iff (I_RST)
    (O_PD_IRQ_N && !next_irq_n) |=> O_PD_IRQ_EVENT ##1 !O_PD_IRQ_EVENT;
  endproperty
  a_r7_irq: assert property (p_r7_irq) else $error("Companion interrupt event wrong."); // see R7

  property p_r8_audio;
    @(posedge I_REF_CLK) disable iff (I_RST)
    !bad_audio;
  endproperty
  a_r8_audio: assert property (p_r8_audio) else $error("Audio pin direction wrong."); // see R8

  property p_r9_cable;
    @(posedge I_REF_CLK) disable iff (I_RST)
    !bad_cable;
  endproperty
  a_r9_cable: assert property (p_r9_cable) else $error("Port 1 enable not driven."); // see R9

  property p_r10_default;
    @(posedge I_REF_CLK) disable iff (I_RST)
    $rose(loaded) |-> sel[4] == (cfg2 ? PFMUX_FN_MICROPHONE_PRESENT : PFMUX_FN_CORE) && sel[15] == PFMUX_FN_PD_COMPANION_IRQ_IN;
  endproperty
  a_r10_default: assert property (p_r10_default) else $error("Strap default wrong."); // see R10

  property p_r11_isolated;
    @(posedge I_REF_CLK) disable iff (I_RST)
    (O_WR_ACCEPT && I_WR_PIN != 5'h00) |=> $stable(sel[0]);
  endproperty
  a_r11_isolated: assert property (p_r11_isolated) else $error("Write disturbed another pin."); // see R11
endmodule
`default_nettype wire

/* File: tb/pfmux_ext_model.sv */
// Model of the board wiring around the programmable function pins.
// Assumes pin drive from the multiplexer and outside levels chosen by the bench.
`timescale 1ns/10ps
`default_nettype none
module pfmux_ext_model
(
  input wire logic i_rst,
  input wire logic [28:0] i_ext,
  input wire logic [28:0] i_pin_out,
  input wire logic [28:0] i_pin_oe_n,
  output logic [28:0] o_pin
);
  // ==========================================================
  // Pin levels seen by the multiplexer.
  always_comb
  begin
    for (int i = 0; i < 29; i++)
    begin
      o_pin[i] = i_pin_oe_n[i] ? i_ext[i] : i_pin_out[i];
    end
    if (i_rst)
    begin
      o_pin[18] = 1'h0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/programmable_function_pin_mux_test.sv */
// Self-checking bench of the programmable function pin multiplexer.
// Assumes the design and package files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module programmable_function_pin_mux_test;
  import pfmux_pkg::*;
  logic I_REF_CLK, I_RST, I_CFG_STAGE, I_ENUMERATED, I_SPI_EN, I_POWERDOWN, I_WR_EN;
  logic O_WR_ACCEPT, O_MICROPHONE_PRESENT, O_PD_IRQ_N, O_PD_IRQ_EVENT, O_DEFAULTS_LOADED;
  logic [1:0] I_CFG_STRAP;
  logic [4:0] I_WR_PIN;
  pfmux_func_t I_WR_FUNC;
  pfmux_src_t I_WR_SRC;
  logic [21:0] I_FUNC_OUT, I_FUNC_OE, O_FUNC_IN;
  logic [28:0] I_CORE_OUT, I_CORE_OE, I_PF_IN, O_PF_OUT, O_PF_OE_N, ext;
  int errors = 0;
  int checked = 0;

  // ==========================================================
  // Design and board model.
  pfmux_top u_pfmux_top (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_CFG_STRAP(I_CFG_STRAP),
    .I_CFG_STAGE(I_CFG_STAGE), .I_ENUMERATED(I_ENUMERATED), .I_SPI_EN(I_SPI_EN),
    .I_POWERDOWN(I_POWERDOWN), .I_WR_EN(I_WR_EN), .I_WR_PIN(I_WR_PIN), .I_WR_FUNC(I_WR_FUNC),
    .I_WR_SRC(I_WR_SRC), .O_WR_ACCEPT(O_WR_ACCEPT), .I_FUNC_OUT(I_FUNC_OUT), .I_FUNC_OE(I_FUNC_OE),
    .O_FUNC_IN(O_FUNC_IN), .I_CORE_OUT(I_CORE_OUT), .I_CORE_OE(I_CORE_OE), .I_PF_IN(I_PF_IN),
    .O_PF_OUT(O_PF_OUT), .O_PF_OE_N(O_PF_OE_N), .O_MICROPHONE_PRESENT(O_MICROPHONE_PRESENT),
    .O_PD_IRQ_N(O_PD_IRQ_N), .O_PD_IRQ_EVENT(O_PD_IRQ_EVENT), .O_DEFAULTS_LOADED(O_DEFAULTS_LOADED));
  pfmux_ext_model u_pfmux_ext_model (.i_rst(I_RST), .i_ext(ext), .i_pin_out(O_PF_OUT),
    .i_pin_oe_n(O_PF_OE_N), .o_pin(I_PF_IN));

  initial
  begin
    I_REF_CLK = 1'h0;
    forever #20 I_REF_CLK = ~I_REF_CLK;
  end

  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge I_REF_CLK);
  endtask

  task automatic do_reset(input logic [1:0] strap);
    I_RST = 1'h1;
    I_CFG_STRAP = strap;
    step(12);
    chk(O_PF_OE_N, 29'h1FFFFFFF);
    chk(O_DEFAULTS_LOADED, 1'h0);
    I_RST = 1'h0;
    step(1);
    chk(O_DEFAULTS_LOADED, 1'h1);
  endtask

  task automatic wr(input logic [4:0] pin, input pfmux_func_t fn, input pfmux_src_t src, input logic acc);
    @(negedge I_REF_CLK);
    I_WR_EN = 1'h1;
    I_WR_PIN = pin;
    I_WR_FUNC = fn;
    I_WR_SRC = src;
    #1;
    chk(O_WR_ACCEPT, acc);
    step(1);
    I_WR_EN = 1'h0;
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_cfg1_outputs();
    I_FUNC_OUT = 22'h380000;
    step(1);
    chk({O_PF_OE_N[2:0], O_PF_OUT[2:0]}, 6'h07);
    I_FUNC_OUT = 22'h200000;
    step(1);
    chk(O_PF_OUT[2:0], 3'h4);
    I_SPI_EN = 1'h1;
    I_FUNC_OUT = 22'h000A00;
    step(1);
    chk({O_PF_OE_N[22:19], O_PF_OUT[22:19]}, 8'h0A);
    I_SPI_EN = 1'h0;
    step(1);
    chk(O_PF_OE_N[22:19], 4'hF);
    I_SPI_EN = 1'h1;
    I_POWERDOWN = 1'h1;
    I_FUNC_OUT = 22'h000000;
    step(1);
    chk({O_PF_OE_N[17], O_PF_OUT[17]}, 2'h1);
    I_POWERDOWN = 1'h0;
  endtask

  task automatic t_irq();
    ext[15] = 1'h0;
    step(1);
    chk({O_PD_IRQ_N, O_PD_IRQ_EVENT}, 2'h1);
    step(1);
    chk({O_PD_IRQ_N, O_PD_IRQ_EVENT}, 2'h0);
    ext[15] = 1'h1;
  endtask

  task automatic t_writes();
    chk({O_PF_OE_N[6:5], O_PF_OUT[6]}, 3'h1);
    wr(5'h05, PFMUX_FN_MICROPHONE_PRESENT, PFMUX_SRC_OTP, 1'h1);
    chk({O_PF_OE_N[6:5], O_PF_OUT[6]}, 3'h3);
    ext[5] = 1'h1;
    step(2);
    chk(O_MICROPHONE_PRESENT, 1'h1);
    ext[5] = 1'h0;
    step(2);
    chk(O_MICROPHONE_PRESENT, 1'h0);
    wr(5'h06, PFMUX_FN_NONE, PFMUX_SRC_SMBUS_RUNTIME, 1'h0);
    wr(5'h06, PFMUX_FN_NONE, PFMUX_SRC_USB_RUNTIME, 1'h0);
    wr(5'h1D, PFMUX_FN_NONE, PFMUX_SRC_OTP, 1'h0);
    wr(5'h06, PFMUX_FN_NONE, PFMUX_SRC_CFG_STAGE, 1'h0);
    chk(O_PF_OE_N[6], 1'h0);
    I_CFG_STAGE = 1'h1;
    wr(5'h06, PFMUX_FN_NONE, PFMUX_SRC_CFG_STAGE, 1'h1);
    chk(O_PF_OE_N[6], 1'h1);
    I_CFG_STAGE = 1'h0;
    I_ENUMERATED = 1'h1;
    wr(5'h06, PFMUX_FN_CORE, PFMUX_SRC_USB_RUNTIME, 1'h1);
    wr(5'h06, PFMUX_FN_NONE, PFMUX_SRC_SMBUS_RUNTIME, 1'h1);
    wr(5'h06, PFMUX_FN_CORE, PFMUX_SRC_OTP, 1'h0);
    chk(O_PF_OE_N[6], 1'h1);
  endtask

  task automatic t_audio();
    do_reset(2'h1);
    I_FUNC_OUT = 22'h01E000;
    ext[7] = 1'h1;
    ext[4] = 1'h1;
    step(2);
    chk({O_PF_OUT[25], O_PF_OUT[23], O_PF_OUT[16], O_PF_OUT[8]}, 4'hF);
    chk({O_PF_OE_N[25], O_PF_OE_N[23], O_PF_OE_N[16], O_PF_OE_N[8], O_PF_OE_N[7]}, 5'h01);
    chk({O_FUNC_IN[12], O_MICROPHONE_PRESENT}, 2'h3);
    I_FUNC_OUT = 22'h008000;
    step(1);
    chk({O_PF_OUT[25], O_PF_OUT[23], O_PF_OUT[16], O_PF_OUT[8]}, 4'h8);
  endtask

  // ==========================================================
  // Main sequence and time limit.
  initial
  begin
    I_RST = 1'h1;
    I_CFG_STRAP = 2'h0;
    I_CFG_STAGE = 1'h0;
    I_ENUMERATED = 1'h0;
    I_SPI_EN = 1'h0;
    I_POWERDOWN = 1'h0;
    I_WR_EN = 1'h0;
    I_WR_PIN = 5'h00;
    I_WR_FUNC = PFMUX_FN_NONE;
    I_WR_SRC = PFMUX_SRC_OTP;
    I_FUNC_OUT = 22'h000000;
    I_FUNC_OE = 22'h3FFFFF;
    I_CORE_OUT = 29'h0000040;
    I_CORE_OE = 29'h1FFFFFFF;
    ext = 29'h0008000;
    do_reset(2'h0);
    t_cfg1_outputs();
    t_irq();
    t_writes();
    t_audio();
    end_sim();
  end

  initial
  begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
